// ==== decim_gain_consts.vh ====
// constants for the decimator gain control block
`ifndef DECIM_GAIN_CONSTS_VH
`define DECIM_GAIN_CONSTS_VH

// register addresses and control reset value
`define GAIN_CTRL_ADDR        8'h14
`define GAIN_READBACK_ADDR    8'h15
`define GAIN_CTRL_RESET       8'h00

// control byte fields
`define GAIN_OVERRIDE_BIT     7
`define GAIN_RESERVED_BIT     6
`define GAIN_COARSE_MSB       5
`define GAIN_COARSE_LSB       3
`define GAIN_FINE_MSB         2
`define GAIN_FINE_LSB         0

// gain factor = numerator / divisor
`define GAIN_NUM_BASE         7'h20
`define GAIN_DIVISOR          24'sh00001A
`define GAIN_NUM_CLIPPING     7'h1A
`define GAIN_NUM_RECOVERY     7'h23

// sample widths and mapping
`define FILTER_WIDTH          16
`define SAMPLE_WIDTH          12
`define MAP_SHIFT             4
`define SAMPLE_POS_LIMIT      24'sh0007FF
`define SAMPLE_NEG_LIMIT      24'shFFF800
`define SAMPLE_POS_FULL       12'h7FF
`define SAMPLE_NEG_FULL       12'h800

`endif

// ==== decimator_gain_control.v ====
// decimator gain control register and output gain selection
`timescale 1ns/1ps
`default_nettype none
`include "decim_gain_consts.vh"

module decimator_gain_control
(
  input  wire                       sys_clk,
  input  wire                       rst_n,
  input  wire [7:0]                 reg_addr,
  input  wire [7:0]                 reg_wdata,
  input  wire                       reg_wr,
  input  wire                       reg_rd,
  output reg  [7:0]                 reg_rdata,
  input  wire                       overload_recovery_mode,
  input  wire [`FILTER_WIDTH-1:0]   filter_data,
  input  wire                       filter_valid,
  output wire [`SAMPLE_WIDTH-1:0]   sample_out,
  output wire                       sample_valid,
  output wire                       sample_saturated,
  output wire [6:0]                 gain_factor,
  output wire                       custom_gain_override
);

  reg  [7:0]                        gain_ctrl;
  wire [2:0]                        coarse_code;
  wire [2:0]                        fine_code;
  wire [2:0]                        coarse_coeff_value;
  wire [2:0]                        fine_coeff_value;
  wire [6:0]                        custom_num;
  wire [6:0]                        auto_num;
  reg  [6:0]                        next_gain_num;

  // maps a 3-bit code to a signed value, unused codes fold to +2 or -2
  function [2:0] coeff_decode;
    input [2:0] code;
    begin
      case (code)
        3'h3:    coeff_decode = 3'h2;
        3'h2:    coeff_decode = 3'h2;
        3'h1:    coeff_decode = 3'h1;
        3'h0:    coeff_decode = 3'h0;
        3'h7:    coeff_decode = 3'h7;
        3'h6:    coeff_decode = 3'h6;
        3'h5:    coeff_decode = 3'h6;
        3'h4:    coeff_decode = 3'h6;
        default: coeff_decode = 3'h0;
      endcase
    end
  endfunction

  // control byte write, only at the primary address
  always @(posedge sys_clk)
  begin
    if (!rst_n)
      gain_ctrl <= `GAIN_CTRL_RESET;
    else if (reg_wr && reg_addr == `GAIN_CTRL_ADDR)
      gain_ctrl <= reg_wdata;
  end

  // read port: primary address is write-only and reads zero
  always @(posedge sys_clk)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      if (reg_addr == `GAIN_READBACK_ADDR)
        reg_rdata <= gain_ctrl;
      else
        reg_rdata <= 8'h00;
    end
  end

  assign custom_gain_override = gain_ctrl[`GAIN_OVERRIDE_BIT];
  assign coarse_code = gain_ctrl[`GAIN_COARSE_MSB:`GAIN_COARSE_LSB];
  assign fine_code   = gain_ctrl[`GAIN_FINE_MSB:`GAIN_FINE_LSB];

  assign coarse_coeff_value = coeff_decode(coarse_code);
  assign fine_coeff_value   = coeff_decode(fine_code);

  // numerator over the fixed divisor, wraps safely since result is 22..42
  assign custom_num = `GAIN_NUM_BASE
                    + {{2{coarse_coeff_value[2]}}, coarse_coeff_value, 2'b00}
                    + {{4{fine_coeff_value[2]}}, fine_coeff_value};

  // 26/26 is 0 dB, 35/26 is about 2.6 dB
  assign auto_num = overload_recovery_mode ? `GAIN_NUM_RECOVERY
                                           : `GAIN_NUM_CLIPPING;

  always @*
  begin
    if (custom_gain_override)
      next_gain_num = custom_num;
    else
      next_gain_num = auto_num;
  end

  gain_scaler u_scaler
  (
    .sys_clk          (sys_clk),
    .rst_n            (rst_n),
    .filter_data      (filter_data),
    .filter_valid     (filter_valid),
    .gain_num         (next_gain_num),
    .sample_out       (sample_out),
    .sample_valid     (sample_valid),
    .sample_saturated (sample_saturated),
    .applied_num      (gain_factor)
  );

endmodule

`default_nettype wire

// ==== decimator_gain_control_bench.sv ====
// self-checking bench for the decimator gain control block
`timescale 1ns/1ps
`default_nettype none
module decimator_gain_control_bench;
  logic        sys_clk = 0, rst_n = 0, wr_s = 0, rd_s = 0, orm = 0, fv = 0;
  logic [7:0]  ra = 0, wd = 0, rdat;
  logic [15:0] fd = 0;
  logic [11:0] so;
  logic [6:0]  gf;
  logic        sv, ss, cgo;
  integer      fails = 0, checks_done = 0, i, p;
  integer      dv [8] = '{0, 1, 2, 2, -2, -2, -2, -1};
  decimator_gain_control uut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(ra),
    .reg_wdata(wd), .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdat),
    .overload_recovery_mode(orm), .filter_data(fd), .filter_valid(fv),
    .sample_out(so), .sample_valid(sv), .sample_saturated(ss),
    .gain_factor(gf), .custom_gain_override(cgo));
  initial forever #12.5 sys_clk = ~sys_clk;
  task chk(input logic [11:0] got, input logic [11:0] exp);
  begin
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
  begin
    @(posedge sys_clk);
    ra <= a;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge sys_clk);
    wr_s <= 1'b0;
  end
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
  begin
    @(posedge sys_clk);
    ra <= a;
    rd_s <= 1'b1;
    @(posedge sys_clk);
    rd_s <= 1'b0;
    @(posedge sys_clk);
    #1 chk(rdat, e);
  end
  endtask
  task smp(input logic [15:0] d, input integer n);
  begin
    @(posedge sys_clk);
    fd <= d;
    fv <= 1'b1;
    @(posedge sys_clk);
    fv <= 1'b0;
    @(posedge sys_clk);
    p = $signed(d) * n / 26 >>> 4;
    #1 chk(gf, 12'(n));
    chk(sv, 12'h001);
    chk(so, (p > 2047) ? 12'h7FF : ((p < -2048) ? 12'h800 : p[11:0]));
    chk(ss, 12'(p > 2047 || p < -2048));
  end
  endtask
  task give_verdict;
  begin
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  initial
  begin
    #50000;
    fails++;
    give_verdict;
  end
  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(8'h15, 8'h00);
    wr(8'h16, 8'hFF);
    rd(8'h15, 8'h00);
    wr(8'h14, 8'h3A);
    rd(8'h15, 8'h3A);
    rd(8'h14, 8'h00);
    chk(cgo, 12'h000);
    smp(16'h4000, 26);
    @(posedge sys_clk);
    orm <= 1'b1;
    smp(16'h4000, 35);
    for (i = 0; i < 8; i++)
    begin
      wr(8'h14, {5'b10000, i[2:0]});
      smp(16'h4000, 32 + dv[i]);
      wr(8'h14, {2'b10, i[2:0], 3'b000});
      smp(16'hC000, 32 + 4 * dv[i]);
    end
    // write taken at the same edge as a sample leaves that sample alone
    fork
      smp(16'h4000, 28);
      wr(8'h14, 8'h92);
    join
    chk(cgo, 12'h001);
    smp(16'h7FFF, 42);
    smp(16'h8000, 42);
    give_verdict;
  end
endmodule
bind decimator_gain_control decimator_gain_control_chk chk (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .overload_recovery_mode(overload_recovery_mode),
  .filter_data(filter_data),
  .filter_valid(filter_valid),
  .sample_out(sample_out),
  .sample_valid(sample_valid),
  .sample_saturated(sample_saturated),
  .gain_factor(gain_factor),
  .custom_gain_override(custom_gain_override));
`default_nettype wire

// ==== decimator_gain_control_chk.sv ====
// checker for the decimator gain control block
`timescale 1ns/1ps
`default_nettype none
module decimator_gain_control_chk
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        overload_recovery_mode,
  input wire logic [15:0] filter_data,
  input wire logic        filter_valid,
  input wire logic [11:0] sample_out,
  input wire logic        sample_valid,
  input wire logic        sample_saturated,
  input wire logic [6:0]  gain_factor,
  input wire logic        custom_gain_override
);
  logic [7:0]  sh;
  logic [6:0]  en;
  logic [11:0] es;
  integer      p;
  function automatic integer dc(input logic [2:0] c);
    dc = c[2] ? ((c == 3'h7) ? -1 : -2) : (c[1] ? 2 : int'(c[0]));
  endfunction
  always_ff @(posedge sys_clk)
    if (!rst_n)
      sh <= 8'h00;
    else if (reg_wr && reg_addr == 8'h14)
      sh <= reg_wdata;
  always_comb
  begin
    en = sh[7] ? 7'(32 + 4 * dc(sh[5:3]) + dc(sh[2:0]))
               : (overload_recovery_mode ? 7'h23 : 7'h1A);
    p = $signed(filter_data) * int'(en) / 26 >>> 4;
    es = (p > 2047) ? 12'h7FF : ((p < -2048) ? 12'h800 : p[11:0]);
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_rb; reg_rd && reg_addr == 8'h15 |=> reg_rdata == $past(sh); endproperty
  a_rb: assert property (p_rb) else $error("readback mismatch");
  property p_rz; reg_rd && reg_addr != 8'h15 |=> reg_rdata == 8'h00; endproperty
  a_rz: assert property (p_rz) else $error("other read not zero");
  property p_ovr; custom_gain_override == sh[7]; endproperty
  a_ovr: assert property (p_ovr) else $error("override bit wrong");
  property p_auto; filter_valid && !sh[7] |-> ##2 gain_factor == $past(en, 2); endproperty
  a_auto: assert property (p_auto) else $error("auto gain wrong");
  property p_cust; filter_valid && sh[7] |-> ##2 gain_factor == $past(en, 2); endproperty
  a_cust: assert property (p_cust) else $error("custom gain wrong");
  property p_val; filter_valid |-> ##2 sample_valid; endproperty
  a_val: assert property (p_val) else $error("sample missing");
  property p_nov; !filter_valid |-> ##2 !sample_valid; endproperty
  a_nov: assert property (p_nov) else $error("extra sample");
  property p_smp; filter_valid |-> ##2 sample_out == $past(es, 2); endproperty
  a_smp: assert property (p_smp) else $error("sample value wrong");
  property p_hold; !sample_valid |-> $stable(gain_factor); endproperty
  a_hold: assert property (p_hold) else $error("gain moved");
endmodule
`default_nettype wire

// ==== gain_scaler.v ====
// two-stage scaler: applies gain factor and maps to 12-bit samples
`timescale 1ns/1ps
`default_nettype none
`include "decim_gain_consts.vh"

module gain_scaler
(
  input  wire                       sys_clk,
  input  wire                       rst_n,
  input  wire [`FILTER_WIDTH-1:0]   filter_data,
  input  wire                       filter_valid,
  input  wire [6:0]                 gain_num,
  output reg  [`SAMPLE_WIDTH-1:0]   sample_out,
  output reg                        sample_valid,
  output reg                        sample_saturated,
  output reg  [6:0]                 applied_num
);

  reg  signed [`FILTER_WIDTH-1:0]   held_data;
  reg         [6:0]                 held_num;
  reg                               held_valid;
  wire signed [23:0]                product;
  wire signed [23:0]                quotient;
  wire signed [23:0]                mapped;

  // gain captured with the sample so a later write never touches it
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      held_data  <= {`FILTER_WIDTH{1'b0}};
      held_num   <= `GAIN_NUM_CLIPPING;
      held_valid <= 1'b0;
    end
    else
    begin
      held_valid <= filter_valid;
      if (filter_valid)
      begin
        held_data <= filter_data;
        held_num  <= gain_num;
      end
    end
  end

  // scale by numerator over divisor, then drop to the output word
  assign product  = held_data * $signed({1'b0, held_num});
  assign quotient = product / `GAIN_DIVISOR;
  assign mapped   = quotient >>> `MAP_SHIFT;

  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      sample_out       <= {`SAMPLE_WIDTH{1'b0}};
      sample_valid     <= 1'b0;
      sample_saturated <= 1'b0;
      applied_num      <= `GAIN_NUM_CLIPPING;
    end
    else
    begin
      sample_valid <= held_valid;
      if (held_valid)
      begin
        applied_num <= held_num;
        if (mapped > `SAMPLE_POS_LIMIT)
        begin
          sample_out       <= `SAMPLE_POS_FULL;
          sample_saturated <= 1'b1;
        end
        else if (mapped < `SAMPLE_NEG_LIMIT)
        begin
          sample_out       <= `SAMPLE_NEG_FULL;
          sample_saturated <= 1'b1;
        end
        else
        begin
          sample_out       <= mapped[`SAMPLE_WIDTH-1:0];
          sample_saturated <= 1'b0;
        end
      end
    end
  end

endmodule

`default_nettype wire
